// ==== rtl/smrc_defines.svh ====
/*
 Constants for the mode register configuration pair:
 register select codes, field positions, reset values and timing counts.
 Assumes inclusion by bare name from the device, controller, checker and testbench files.
*/
// Operation
// [R1] Controller keeps test mode bit at zero
// [R2] DLL reset bit clears itself after reset
// [R3] Controller waits lock time after DLL reset
// [R4] Write recovery field times write autoprecharge
// [R5] Write recovery no less than ceiling time/period
// [R6] A12 selects slow or fast power-down exit
// [R7] Second register write uses bank code 001
// [R8] Bank bits 1:0 select register, bit2 low
// [R9] Second register reserved bits driven zero
// [R10] Third register reserved bits driven zero
// [R11] DLL off in self refresh, back after
// [R12] Clock enable held high during lock time
// [R13] Writes need DLL only with write termination
// [R14] DLL-off: nominal termination off or pin low
// [R15] DLL-off: write termination bits set zero
// [R16] Driver impedance from A1 and A5
// [R17] Write termination applies even nominal off
// [R18] Additive latency delays commands; latency sums
// [R19] A4:A3 decode additive latency; 11 reserved
// [R20] Output disable bit disconnects data drivers
// [R21] Strobe bit swaps data mask for termination
// [R22] Strobe bit zero on non-eight-bit parts
// [R23] Latch only selected register on mode set
`ifndef SMRC_DEFINES_SVH
`define SMRC_DEFINES_SVH

`define SMRC_SEL_FIRST 2'h0
`define SMRC_SEL_SECOND 2'h1
`define SMRC_SEL_THIRD 2'h2
`define SMRC_SEL_FOURTH 2'h3
`define SMRC_MR_RESET 16'h0000
// First register fields
`define SMRC_F0_TEST 7
`define SMRC_F0_DLLRST 8
`define SMRC_F0_WR_LO 9
`define SMRC_F0_WR_HI 11
`define SMRC_F0_PPD 12
`define SMRC_F0_CL_LO 4
`define SMRC_F0_CL_HI 6
// Second register fields
`define SMRC_F1_DLLDIS 0
`define SMRC_F1_DIC0 1
`define SMRC_F1_DIC1 5
`define SMRC_F1_RTT0 2
`define SMRC_F1_RTT1 6
`define SMRC_F1_RTT2 9
`define SMRC_F1_AL_LO 3
`define SMRC_F1_AL_HI 4
`define SMRC_F1_WLVL 7
`define SMRC_F1_TSTRB 11
`define SMRC_F1_QOFF 12
`define SMRC_F1_RSVD 16'hE500
// Third register fields and the fourth register reserved mask
`define SMRC_F2_CWL_LO 3
`define SMRC_F2_CWL_HI 4
`define SMRC_F2_RTTWR_LO 9
`define SMRC_F2_RTTWR_HI 10
`define SMRC_F2_RSVD 16'hF920
`define SMRC_F3_RSVD 16'hFFF8
// Write recovery code map: code 0 means 16 cycles, 1..7 map to 5..11
`define SMRC_WR_BASE 5'h04
`define SMRC_WR_MAX 5'h10
// Timing figures in ns and the cycle counts at 100 ns per cycle
`define SMRC_TCK_NS 100
`define SMRC_TWR_NS 15
`define SMRC_WR_MIN ((`SMRC_TWR_NS + `SMRC_TCK_NS - 1) / `SMRC_TCK_NS)
`define SMRC_DLLK_CYC 512
`define SMRC_XP_CYC 3
`define SMRC_XPDLL_CYC 10
`define SMRC_TRP_CYC 5
`define SMRC_AL_RSVD 2'h3
// Latency field offsets: field value plus base gives cycles
`define SMRC_CL_BASE 5'h04
`define SMRC_CWL_BASE 5'h05
// Controller register offsets on the configuration bus
`define SMRC_A_CMD 12'h000
`define SMRC_A_STAT 12'h004
`define SMRC_A_CFG 12'h008

`endif

// ==== rtl/smrc_pkg.sv ====
/*
 Types for the mode register link; only the device end uses them.
 Assumes smrc_defines.svh for all numbers.
*/
package smrc_pkg;
    typedef enum logic [1:0] {
        SMRC_AL_OFF,
        SMRC_AL_CL1,
        SMRC_AL_CL2,
        SMRC_AL_BAD
    } smrc_al_t;
    typedef enum logic [2:0] {
        SMRC_CMD_NOP,
        SMRC_CMD_MRS,
        SMRC_CMD_SRE,
        SMRC_CMD_SRX,
        SMRC_CMD_PDE,
        SMRC_CMD_PDX,
        SMRC_CMD_WRA
    } smrc_cmd_t;
endpackage

// ==== rtl/smrc_if.sv ====
/*
 Command pins between controller and device, plus the device's pin
 level answers. Assumes one shared sys_clk.
*/
`timescale 1ns/1ps
interface smrc_if (
    input wire logic sys_clk
);
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
    logic die_termination_ctrl;
    logic [2:0] bank_sel;
    logic [15:0] addr;
    logic cmd_ready;

    modport ctrl (
        output cs_n, ras_n, cas_n, we_n, cke, die_termination_ctrl,
        output bank_sel, addr,
        input cmd_ready
    );
    modport dev (
        input cs_n, ras_n, cas_n, we_n, cke, die_termination_ctrl,
        input bank_sel, addr,
        output cmd_ready
    );
endinterface

// ==== rtl/smrc_device.sv ====
/*
 Device end: decodes the mode set command, holds the four mode registers
 and derives the settings the data path uses.
 Assumes command pins synchronous to sys_clk and a legal controller.
*/
// Local design decisions: the APB register port and the address map.
`timescale 1ns/1ps
`include "smrc_defines.svh"
module smrc_device (
    input wire logic sys_clk,
    input wire logic reset_n,
    smrc_if.dev link,
    output logic [15:0] first_mode_register,
    output logic [15:0] second_mode_register,
    output logic [15:0] third_mode_register,
    output logic [15:0] fourth_mode_register,
    output logic dll_running,
    output logic dll_locked,
    output logic self_refresh,
    output logic [4:0] additive_latency,
    output logic [4:0] total_read_latency,
    output logic [4:0] total_write_latency,
    output logic [4:0] autoprecharge_write_delay,
    output logic [4:0] pd_exit_delay,
    output logic [1:0] drive_strength,
    output logic [2:0] nominal_term,
    output logic [1:0] write_term,
    output logic write_dll_needed,
    output logic outputs_off,
    output logic data_mask_en,
    output logic termination_strobe_en
);
    logic cmd_mrs;
    logic cmd_sre;
    logic cmd_srx;
    logic [4:0] cl;
    logic [4:0] write_column_latency;
    logic [4:0] wr;
    logic [4:0] next_al;
    logic [9:0] lock_cnt;
    logic [15:0] m0;
    logic [15:0] m1;
    logic [15:0] m2;

    // Command decode; self refresh uses clock enable edges
    assign cmd_mrs = link.cke && !link.cs_n && !link.ras_n && !link.cas_n
                     && !link.we_n;
    assign cmd_sre = !link.cke && !self_refresh && !link.cs_n
                     && !link.ras_n && !link.cas_n && link.we_n;
    assign cmd_srx = link.cke && self_refresh;
    assign link.cmd_ready = 1'b1;
    assign m0 = first_mode_register;
    assign m1 = second_mode_register;
    assign m2 = third_mode_register;

    // Mode register latch; DLL reset bit clears itself next cycle
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            first_mode_register <= `SMRC_MR_RESET;
            second_mode_register <= `SMRC_MR_RESET;
            third_mode_register <= `SMRC_MR_RESET;
            fourth_mode_register <= `SMRC_MR_RESET;
        end else if (cmd_mrs) begin
            unique case (link.bank_sel[1:0]) // R8
                `SMRC_SEL_FIRST: first_mode_register <= link.addr; // R23
                `SMRC_SEL_SECOND: second_mode_register <= link.addr; // R23
                `SMRC_SEL_THIRD: third_mode_register <= link.addr; // R23
                `SMRC_SEL_FOURTH: fourth_mode_register <= link.addr; // R23
            endcase
        end else if (first_mode_register[`SMRC_F0_DLLRST]) begin
            first_mode_register[`SMRC_F0_DLLRST] <= 1'b0; // R2
        end
    end

    // Self refresh state
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            self_refresh <= 1'b0;
        end else if (cmd_sre) begin
            self_refresh <= 1'b1;
        end else if (cmd_srx) begin
            self_refresh <= 1'b0;
        end
    end

    // DLL runs when enabled, stops in self refresh and precharge
    // power-down with slow exit; a reset restarts the lock count
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            dll_running <= 1'b0;
            dll_locked <= 1'b0;
            lock_cnt <= 10'h000;
        end else begin
            dll_running <= !m1[`SMRC_F1_DLLDIS] && !self_refresh // R11
                           && (link.cke || m0[`SMRC_F0_PPD]); // R6
            if (m0[`SMRC_F0_DLLRST]) begin
                lock_cnt <= 10'h000;
                dll_locked <= 1'b0;
            end else if (!dll_running) begin
                dll_locked <= 1'b0;
            end else if (lock_cnt == 10'(`SMRC_DLLK_CYC - 1)) begin
                dll_locked <= 1'b1;
            end else begin
                lock_cnt <= lock_cnt + 10'h001;
            end
        end
    end

    // Latency decode from register fields
    always_comb begin
        cl = 5'(m0[`SMRC_F0_CL_HI:`SMRC_F0_CL_LO]) + `SMRC_CL_BASE;
        write_column_latency = 5'(m2[`SMRC_F2_CWL_HI:`SMRC_F2_CWL_LO]) + `SMRC_CWL_BASE;
        if (m0[`SMRC_F0_WR_HI:`SMRC_F0_WR_LO] == 3'h0) begin
            wr = `SMRC_WR_MAX;
        end else begin
            wr = 5'(m0[`SMRC_F0_WR_HI:`SMRC_F0_WR_LO]) + `SMRC_WR_BASE; // R4
        end
        unique case (smrc_pkg::smrc_al_t'(m1[`SMRC_F1_AL_HI:`SMRC_F1_AL_LO]))
            smrc_pkg::SMRC_AL_OFF: next_al = 5'h00; // R19
            smrc_pkg::SMRC_AL_CL1: next_al = cl - 5'h01; // R19
            smrc_pkg::SMRC_AL_CL2: next_al = cl - 5'h02; // R19
            smrc_pkg::SMRC_AL_BAD: next_al = 5'h00; // R19
        endcase
    end

    // Registered settings for the data path
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            additive_latency <= 5'h00;
            total_read_latency <= 5'h00;
            total_write_latency <= 5'h00;
            autoprecharge_write_delay <= 5'h00;
            pd_exit_delay <= 5'h00;
        end else begin
            additive_latency <= next_al; // R18
            total_read_latency <= next_al + cl; // R18
            total_write_latency <= next_al + write_column_latency; // R18
            autoprecharge_write_delay <= wr + 5'(`SMRC_TRP_CYC); // R4
            pd_exit_delay <= m0[`SMRC_F0_PPD] ? 5'(`SMRC_XP_CYC)
                             : 5'(`SMRC_XPDLL_CYC); // R6
        end
    end

    // Termination, driver and pin function settings
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            drive_strength <= 2'h0;
            nominal_term <= 3'h0;
            write_term <= 2'h0;
            write_dll_needed <= 1'b0;
            outputs_off <= 1'b0;
            data_mask_en <= 1'b1;
            termination_strobe_en <= 1'b0;
        end else begin
            drive_strength <= {m1[`SMRC_F1_DIC1], m1[`SMRC_F1_DIC0]}; // R16
            nominal_term <= {m1[`SMRC_F1_RTT2], m1[`SMRC_F1_RTT1],
                             m1[`SMRC_F1_RTT0]};
            write_term <= m1[`SMRC_F1_WLVL] ? 2'h0
                          : m2[`SMRC_F2_RTTWR_HI:`SMRC_F2_RTTWR_LO]; // R17
            write_dll_needed <= !m1[`SMRC_F1_WLVL]
                                && (m2[`SMRC_F2_RTTWR_HI:`SMRC_F2_RTTWR_LO]
                                != 2'h0); // R13
            outputs_off <= m1[`SMRC_F1_QOFF]; // R20
            data_mask_en <= !m1[`SMRC_F1_TSTRB]; // R21
            termination_strobe_en <= m1[`SMRC_F1_TSTRB]; // R21
        end
    end
endmodule

// ==== rtl/smrc_controller.sv ====
/*
 Controller end: takes mode set orders over APB and drives the mode set
 command on the link, then waits lock or exit times as needed.
 Assumes the device end on the same sys_clk.
*/
`timescale 1ns/1ps
`include "smrc_defines.svh"
module smrc_controller (
    input wire logic sys_clk,
    input wire logic reset_n,
    smrc_if.ctrl link,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    typedef enum logic [1:0] {SMRC_IDLE, SMRC_ISSUE, SMRC_WAIT} smrc_st_t;
    smrc_st_t state;
    logic [9:0] wait_cnt;
    logic [1:0] pend_sel;
    logic [15:0] pend_data;
    logic dll_off_mode;
    logic rejected;
    logic acc;
    logic [15:0] clean;

    assign acc = psel && penable;
    // Reserved bits of the second to fourth registers forced low, test bit forced low, strobe bit low unless pwdata[20] set
    always_comb begin
        clean = pwdata[15:0];
        clean[`SMRC_F0_TEST] = (pwdata[17:16] == `SMRC_SEL_FIRST)
                               ? 1'b0 : pwdata[`SMRC_F0_TEST]; // R1
        unique case (pwdata[17:16])
            `SMRC_SEL_FIRST: clean = clean;
            `SMRC_SEL_SECOND: clean = clean & ~`SMRC_F1_RSVD; // R9
            `SMRC_SEL_THIRD: clean = clean & ~`SMRC_F2_RSVD; // R10
            `SMRC_SEL_FOURTH: clean = clean & ~`SMRC_F3_RSVD;
        endcase
        if (pwdata[17:16] == `SMRC_SEL_SECOND && !pwdata[20]) begin
            clean[`SMRC_F1_TSTRB] = 1'b0; // R22
        end
        if (pwdata[17:16] == `SMRC_SEL_SECOND && clean[`SMRC_F1_DLLDIS]) begin
            clean[`SMRC_F1_RTT0] = 1'b0; // R14
            clean[`SMRC_F1_RTT1] = 1'b0; // R14
            clean[`SMRC_F1_RTT2] = 1'b0; // R14
        end
        if (pwdata[17:16] == `SMRC_SEL_THIRD && dll_off_mode) begin
            clean[`SMRC_F2_RTTWR_HI:`SMRC_F2_RTTWR_LO] = 2'h0; // R15
        end
        if (pwdata[17:16] == `SMRC_SEL_FIRST
            && pwdata[`SMRC_F0_WR_HI:`SMRC_F0_WR_LO] != 3'h0
            && 5'(pwdata[`SMRC_F0_WR_HI:`SMRC_F0_WR_LO]) + `SMRC_WR_BASE
            < 5'(`SMRC_WR_MIN)) begin
            clean[`SMRC_F0_WR_HI:`SMRC_F0_WR_LO] = 3'h0; // R5
        end
    end

    // APB slave: no wait states, write to command register starts
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            rejected <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                unique case (paddr)
                    `SMRC_A_STAT: prdata <= {29'h0, rejected, dll_off_mode,
                                             state != SMRC_IDLE};
                    `SMRC_A_CFG: prdata <= {14'h0, pend_sel, pend_data};
                    default: prdata <= 32'h0000_0000;
                endcase
                pslverr <= !(paddr == `SMRC_A_CMD || paddr == `SMRC_A_STAT
                             || paddr == `SMRC_A_CFG);
            end
            if (acc && pready && pwrite && paddr == `SMRC_A_CMD) begin
                rejected <= state != SMRC_IDLE;
            end
        end
    end

    // Command sequencer
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= SMRC_IDLE;
            wait_cnt <= 10'h000;
            pend_sel <= 2'h0;
            pend_data <= 16'h0000;
            dll_off_mode <= 1'b0;
            link.cs_n <= 1'b1;
            link.ras_n <= 1'b1;
            link.cas_n <= 1'b1;
            link.we_n <= 1'b1;
            link.cke <= 1'b1;
            link.die_termination_ctrl <= 1'b0;
            link.bank_sel <= 3'h0;
            link.addr <= 16'h0000;
        end else begin
            link.cke <= 1'b1; // R12
            unique case (state)
                SMRC_IDLE: begin
                    link.cs_n <= 1'b1;
                    link.ras_n <= 1'b1;
                    link.cas_n <= 1'b1;
                    link.we_n <= 1'b1;
                    if (acc && pready && pwrite && paddr == `SMRC_A_CMD) begin
                        pend_sel <= pwdata[17:16];
                        pend_data <= clean;
                        state <= SMRC_ISSUE;
                    end
                end
                SMRC_ISSUE: begin
                    link.cs_n <= 1'b0; // R7
                    link.ras_n <= 1'b0;
                    link.cas_n <= 1'b0;
                    link.we_n <= 1'b0;
                    link.bank_sel <= {1'b0, pend_sel}; // R8
                    link.addr <= pend_data;
                    if (pend_sel == `SMRC_SEL_SECOND) begin
                        dll_off_mode <= pend_data[`SMRC_F1_DLLDIS];
                    end
                    if (pend_sel == `SMRC_SEL_SECOND
                        && pend_data[`SMRC_F1_DLLDIS]) begin
                        link.die_termination_ctrl <= 1'b0; // R14
                    end
                    wait_cnt <= (pend_sel == `SMRC_SEL_FIRST
                                 && pend_data[`SMRC_F0_DLLRST])
                                ? 10'(`SMRC_DLLK_CYC) // R3
                                : 10'(`SMRC_XPDLL_CYC);
                    state <= SMRC_WAIT;
                end
                SMRC_WAIT: begin
                    link.cs_n <= 1'b1;
                    link.ras_n <= 1'b1;
                    link.cas_n <= 1'b1;
                    link.we_n <= 1'b1;
                    if (wait_cnt == 10'h000) begin
                        state <= SMRC_IDLE;
                    end else begin
                        wait_cnt <= wait_cnt - 10'h001; // R3
                    end
                end
                default: state <= SMRC_IDLE;
            endcase
        end
    end
endmodule

// ==== test/smrc_link_checker.sv ====
/*
 Pin checker for the mode set link between controller and device.
 Assumes it sees the interface signals as plain inputs on one clock.
*/
`timescale 1ns/1ps
`include "smrc_defines.svh"
module smrc_link_checker (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic cke,
    input wire logic die_termination_ctrl,
    input wire logic [2:0] bank_sel,
    input wire logic [15:0] addr,
    input wire logic cmd_ready
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    logic mode_set_command;
    logic first;
    logic [9:0] gap_cnt;
    logic in_lock;
    logic dll_off;
    // Mode set decode and target register
    assign mode_set_command = cke && !cs_n && !ras_n && !cas_n && !we_n;
    assign first = bank_sel[1:0] == `SMRC_SEL_FIRST;
    // Quiet span after each mode set, long after a DLL reset
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            gap_cnt <= 10'h000;
            in_lock <= 1'b0;
        end else if (mode_set_command) begin
            gap_cnt <= (first && addr[`SMRC_F0_DLLRST]) ?
                10'(`SMRC_DLLK_CYC) : 10'(`SMRC_XPDLL_CYC);
            in_lock <= first && addr[`SMRC_F0_DLLRST];
        end else if (gap_cnt != 10'h000) begin
            gap_cnt <= gap_cnt - 10'h001;
        end else begin
            in_lock <= 1'b0;
        end
    end
    // Last DLL state sent to the second register
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            dll_off <= 1'b0;
        end else if (mode_set_command && bank_sel[1:0] == `SMRC_SEL_SECOND) begin
            dll_off <= addr[`SMRC_F1_DLLDIS];
        end
    end
    property p_mrs_pulse;
        mode_set_command |=> $rose(cs_n);
    endproperty
    a_mrs_pulse: assert property (p_mrs_pulse)
        else $error("mode set pins held low too long");
    property p_bank_top;
        mode_set_command |-> !bank_sel[2] && cmd_ready;
    endproperty
    a_bank_top: assert property (p_bank_top)
        else $error("top bank bit high on mode set");
    property p_test_bit;
        mode_set_command && first |-> !addr[`SMRC_F0_TEST];
    endproperty
    a_test_bit: assert property (p_test_bit)
        else $error("test mode bit sent high");
    property p_wr_min;
        mode_set_command && first |-> addr[11:9] == 3'h0 ||
            5'(addr[11:9]) + `SMRC_WR_BASE >= 5'(`SMRC_WR_MIN);
    endproperty
    a_wr_min: assert property (p_wr_min)
        else $error("write recovery below minimum");
    property p_second_rsvd;
        mode_set_command && bank_sel[1:0] == `SMRC_SEL_SECOND |->
            (addr & `SMRC_F1_RSVD) == 16'h0000;
    endproperty
    a_second_rsvd: assert property (p_second_rsvd)
        else $error("second register reserved bits set");
    property p_third_rsvd;
        mode_set_command && bank_sel[1:0] == `SMRC_SEL_THIRD |->
            (addr & `SMRC_F2_RSVD) == 16'h0000;
    endproperty
    a_third_rsvd: assert property (p_third_rsvd)
        else $error("third register reserved bits set");
    property p_mrs_gap;
        gap_cnt != 10'h000 |-> cs_n;
    endproperty
    a_mrs_gap: assert property (p_mrs_gap)
        else $error("command issued inside wait span");
    property p_lock_cke;
        $rose(in_lock) |-> cke [*8];
    endproperty
    a_lock_cke: assert property (p_lock_cke)
        else $error("clock enable dropped in lock span");
    property p_off_nom;
        mode_set_command && bank_sel[1:0] == `SMRC_SEL_SECOND && addr[0] |->
            {addr[9], addr[6], addr[2]} == 3'h0 && !die_termination_ctrl;
    endproperty
    a_off_nom: assert property (p_off_nom)
        else $error("nominal termination left on with DLL off");
    property p_off_wr;
        mode_set_command && dll_off && bank_sel[1:0] == `SMRC_SEL_THIRD |->
            addr[10:9] == 2'h0;
    endproperty
    a_off_wr: assert property (p_off_wr)
        else $error("write termination set with DLL off");
endmodule

// ==== test/tb_top.sv ====
/*
 Testbench: drives the controller over APB and checks the device end.
 Assumes both ends and the link interface compiled before it.
*/
`timescale 1ns/1ps
`include "smrc_defines.svh"
module tb_top;
    logic sys_clk, reset_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [15:0] dev_mr [4];
    logic [15:0] exp_mr [4];
    logic [4:0] al_o, rl_o, wl_o, dal_o, pdx_o;
    logic [1:0] ds_o, wt_o;
    logic [2:0] nt_o;
    logic wdn_o, off_o, dm_o, ts_o, rerr, exp_off, run_o;
    int errors, checks, cl, al, wr;
    integer seed;
    smrc_if lnk (.sys_clk(sys_clk));
    smrc_controller u_smrc_controller (.sys_clk(sys_clk),
        .reset_n(reset_n), .link(lnk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    smrc_device u_smrc_device (.sys_clk(sys_clk), .reset_n(reset_n),
        .link(lnk), .first_mode_register(dev_mr[0]),
        .second_mode_register(dev_mr[1]), .third_mode_register(dev_mr[2]),
        .fourth_mode_register(dev_mr[3]), .dll_running(run_o), .dll_locked(),
        .self_refresh(), .additive_latency(al_o), .total_read_latency(rl_o),
        .total_write_latency(wl_o), .autoprecharge_write_delay(dal_o),
        .pd_exit_delay(pdx_o), .drive_strength(ds_o), .nominal_term(nt_o),
        .write_term(wt_o), .write_dll_needed(wdn_o), .outputs_off(off_o),
        .data_mask_en(dm_o), .termination_strobe_en(ts_o));
    smrc_link_checker u_smrc_link_checker (.sys_clk(sys_clk),
        .reset_n(reset_n), .cs_n(lnk.cs_n), .ras_n(lnk.ras_n),
        .cas_n(lnk.cas_n), .we_n(lnk.we_n), .cke(lnk.cke),
        .die_termination_ctrl(lnk.die_termination_ctrl),
        .bank_sel(lnk.bank_sel), .addr(lnk.addr), .cmd_ready(lnk.cmd_ready));
    // Clock at 100 ns period
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic end_of_test;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk_reg(string n, logic [15:0] e, logic [15:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_val(string n, logic [31:0] e, logic [31:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %0d seen %0d", n, e, g);
        end
    endtask
    // One APB transfer; waits for pready under a bound
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            chk_val("pready", 1, 0);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Value the controller should send after cleaning
    function automatic logic [15:0] san(logic [1:0] s, logic [15:0] v,
        logic ok8);
        logic [15:0] r;
        r = v;
        case (s)
            2'h0: r[`SMRC_F0_TEST] = 1'b0;
            2'h1: begin
                r = r & ~`SMRC_F1_RSVD;
                r[11] = r[11] & ok8;
                if (r[0])
                    r = r & 16'hFDBB;
            end
            2'h2: begin
                r = r & ~`SMRC_F2_RSVD;
                if (exp_off)
                    r[10:9] = 2'h0;
            end
            default: r = r & ~`SMRC_F3_RSVD;
        endcase
        return r;
    endfunction
    task automatic check_all(logic derived);
        for (int i = 0; i < 4; i++)
            chk_reg("mode_register", exp_mr[i], dev_mr[i]);
        if (derived) begin
            cl = exp_mr[0][6:4] + 4;
            al = exp_mr[1][4:3] == 2'h1 ? cl - 1 :
                exp_mr[1][4:3] == 2'h2 ? cl - 2 : 0;
            wr = exp_mr[0][11:9] == 3'h0 ? 16 : exp_mr[0][11:9] + 4;
            chk_val("additive_latency", al, al_o);
            chk_val("total_read_latency", al + cl, rl_o);
            chk_val("total_write_latency", al + exp_mr[2][4:3] + 5, wl_o);
            chk_val("autoprecharge", wr + `SMRC_TRP_CYC, dal_o);
            chk_val("pd_exit", exp_mr[0][12] ? 3 : 10, pdx_o);
            chk_val("drive", {exp_mr[1][5], exp_mr[1][1]}, ds_o);
            chk_val("nominal", {exp_mr[1][9], exp_mr[1][6], exp_mr[1][2]},
                nt_o);
            chk_val("write_term", exp_mr[1][7] ? 0 : exp_mr[2][10:9],
                wt_o);
            chk_val("write_dll", !exp_mr[1][7] && exp_mr[2][10:9] != 2'h0,
                wdn_o);
            chk_val("dll_running", !exp_mr[1][0], run_o);
            chk_val("outputs_off", exp_mr[1][12], off_o);
            chk_val("data_mask", !exp_mr[1][11], dm_o);
            chk_val("strobe", exp_mr[1][11], ts_o);
        end
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            apb(1'b0, 12'h004, 32'h0000_0000);
            n++;
        end while (rdata[0] !== 1'b0 && n < 400);
        if (n >= 400)
            chk_val("busy", 0, 1);
    endtask
    // Send one order, update the model, then check the device end
    task automatic do_cmd(logic [1:0] s, logic [15:0] v, logic ok8);
        logic [15:0] e;
        apb(1'b1, 12'h000, {11'h000, ok8, 2'h0, s, v});
        e = san(s, v, ok8);
        if (s == 2'h1)
            exp_off = e[0];
        if (s == 2'h0)
            e[`SMRC_F0_DLLRST] = 1'b0;
        exp_mr[s] = e;
        wait_idle();
        check_all(1'b1);
    endtask
    // Watchdog
    initial begin
        repeat (80000) @(posedge sys_clk);
        chk_val("watchdog", 0, 1);
        end_of_test();
    end
    initial begin
        seed = 32'hD752;
        {reset_n, psel, penable, pwrite} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        errors = 0;
        checks = 0;
        exp_off = 1'b0;
        for (int i = 0; i < 4; i++)
            exp_mr[i] = `SMRC_MR_RESET;
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        check_all(1'b0);
        apb(1'b0, 12'h0FC, 32'h0000_0000);
        chk_val("unmapped_err", 1, rerr);
        chk_val("unmapped_data", 0, rdata);
        $display("test reset_and_unmapped done");
        do_cmd(2'h0, 16'h1FF4, 1'b0);
        do_cmd(2'h0, 16'h0150, 1'b0);
        for (int i = 0; i < 4; i++)
            do_cmd(2'h1, 16'(i) << 3, 1'b0);
        $display("test latency_codes done");
        do_cmd(2'h1, 16'h0245, 1'b0);
        do_cmd(2'h2, 16'h0618, 1'b0);
        do_cmd(2'h1, 16'h1244, 1'b0);
        do_cmd(2'h2, 16'h0600, 1'b0);
        do_cmd(2'h1, 16'h0800, 1'b0);
        do_cmd(2'h1, 16'h0822, 1'b1);
        $display("test dll_off_and_strobe done");
        apb(1'b1, 12'h000, {14'h0000, 2'h3, 16'h0007});
        apb(1'b1, 12'h000, {14'h0000, 2'h2, 16'h0008});
        apb(1'b0, 12'h004, 32'h0000_0000);
        chk_val("rejected", 1, rdata[2]);
        exp_mr[3] = 16'h0007;
        wait_idle();
        check_all(1'b1);
        $display("test busy_reject done");
        for (int i = 0; i < 30; i++) begin
            rdata = $random(seed);
            if (rdata[17:16] == 2'h0)
                rdata[15:13] = 3'h0;
            do_cmd(rdata[17:16], rdata[15:0], rdata[20]);
        end
        $display("test random_orders done");
        end_of_test();
    end
endmodule
